// ===== design/pin_mux.sv
// programmable pin multiplexer with reset defaults and strap handling
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module pin_mux (
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [pin_mux_pkg::REG_AW-1:0] reg_addr,
  input wire logic [pin_mux_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pin_mux_pkg::REG_DW-1:0] reg_rdata,
  // package pins
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_in,
  output logic [pin_mux_pkg::NUM_PINS-1:0] pad_out,
  output logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe_n,
  output logic [pin_mux_pkg::NUM_PINS-1:0] pad_pull_up,
  output logic [pin_mux_pkg::NUM_PINS-1:0] pad_pull_dn,
  input wire logic address_enable_strap,
  // normal functions from the core
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] norm_out,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] norm_drive,
  output logic [pin_mux_pkg::NUM_PINS-1:0] norm_in,
  // bus cycle information
  input wire logic [pin_mux_pkg::BUS_AW-1:0] bus_addr,
  input wire logic addr_phase,
  input wire logic cycle_end,
  input wire logic bus_hold,
  input wire logic io_space,
  output logic [pin_mux_pkg::NUM_PSEL-1:0] periph_select_n,
  output logic periph_select_seven,
  output logic latched_addr_bit_two,
  output logic strap_low_seen
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [pin_mux_pkg::NUM_PINS-1:0] pad_s1;
    logic [pin_mux_pkg::NUM_PINS-1:0] pad_s2;
    logic strap_s1;
    logic strap_s2;
    pin_mux_pkg::init_state_t init;
    logic strap_low;
    logic [pin_mux_pkg::NUM_PINS-1:0] func_en;
    logic [pin_mux_pkg::NUM_PINS-1:0] dir_out;
    logic [pin_mux_pkg::NUM_PINS-1:0] pull_dn_cfg;
    logic [pin_mux_pkg::NUM_PINS-1:0] out_data;
    logic aux_fn;
    logic [pin_mux_pkg::PB_W-1:0] pbase;
    logic [pin_mux_pkg::REG_DW-1:0] rdata;
    logic [pin_mux_pkg::NUM_PINS-1:0] drv_out;
    logic [pin_mux_pkg::NUM_PINS-1:0] drv_oe_n;
    logic [pin_mux_pkg::NUM_PINS-1:0] pull_up;
    logic [pin_mux_pkg::NUM_PINS-1:0] pull_dn;
  } mux_state_t;

  mux_state_t st_r;
  mux_state_t st_nxt;

  logic [pin_mux_pkg::NUM_PSEL-1:0] psel_n;
  logic addr_two;
  logic shared_val;
  logic [pin_mux_pkg::REG_DW-1:0] rd_word;

  // ****************************************
  // peripheral select decode
  // ****************************************
  periph_decode u_decode (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus_addr(bus_addr),
    .addr_phase(addr_phase),
    .cycle_end(cycle_end),
    .bus_hold(bus_hold),
    .io_space(io_space),
    .pbase_cfg(st_r.pbase),
    .periph_select_n(psel_n),
    .latched_addr_bit_two(addr_two)
  );

  // ****************************************
  // read decode
  // ****************************************
  always_comb begin
    rd_word = pin_mux_pkg::ZERO_WORD;
    case (reg_addr)
      pin_mux_pkg::OFS_FUNC_EN: begin
        rd_word = st_r.func_en;
      end
      pin_mux_pkg::OFS_DIR: begin
        rd_word = st_r.dir_out;
      end
      pin_mux_pkg::OFS_PULL_DN: begin
        rd_word = st_r.pull_dn_cfg;
      end
      pin_mux_pkg::OFS_DATA: begin
        rd_word = st_r.pad_s2;
      end
      pin_mux_pkg::OFS_AUX: begin
        rd_word[pin_mux_pkg::AUX_FN_BIT] = st_r.aux_fn;
      end
      pin_mux_pkg::OFS_PBASE: begin
        rd_word[pin_mux_pkg::PB_W-1:0] = st_r.pbase;
      end
      pin_mux_pkg::OFS_STATUS: begin
        rd_word[pin_mux_pkg::STAT_STRAP_BIT] = st_r.strap_low;
        rd_word[pin_mux_pkg::STAT_READY_BIT] =
          (st_r.init == pin_mux_pkg::ST_RUN);
      end
      pin_mux_pkg::OFS_DRIVEN: begin
        rd_word = ~st_r.drv_oe_n;
      end
      default: begin
        rd_word = pin_mux_pkg::ZERO_WORD;
      end
    endcase
  end

  // ****************************************
  // shared pin source
  // ****************************************
  always_comb begin
    if (st_r.aux_fn) begin
      shared_val = psel_n[pin_mux_pkg::SEL_SEVEN];
    end else begin
      shared_val = addr_two;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;

    // two-stage synchronisers for pins and strap
    st_nxt.pad_s1 = pad_in;
    st_nxt.pad_s2 = st_r.pad_s1;
    st_nxt.strap_s1 = address_enable_strap;
    st_nxt.strap_s2 = st_r.strap_s1;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        pin_mux_pkg::OFS_FUNC_EN: begin
          st_nxt.func_en = reg_wdata;
        end
        pin_mux_pkg::OFS_DIR: begin
          st_nxt.dir_out = reg_wdata;
        end
        pin_mux_pkg::OFS_PULL_DN: begin
          st_nxt.pull_dn_cfg = reg_wdata;
        end
        pin_mux_pkg::OFS_DATA: begin
          st_nxt.out_data = reg_wdata;
        end
        pin_mux_pkg::OFS_AUX: begin
          st_nxt.aux_fn = reg_wdata[pin_mux_pkg::AUX_FN_BIT];
        end
        pin_mux_pkg::OFS_PBASE: begin
          st_nxt.pbase = reg_wdata[pin_mux_pkg::PB_W-1:0];
        end
        default: begin
          st_nxt.aux_fn = st_r.aux_fn;
        end
      endcase
    end

    // strap capture once the synchroniser has filled
    case (st_r.init)
      pin_mux_pkg::ST_FILL0: begin
        st_nxt.init = pin_mux_pkg::ST_FILL1;
      end
      pin_mux_pkg::ST_FILL1: begin
        st_nxt.init = pin_mux_pkg::ST_SAMPLE;
      end
      pin_mux_pkg::ST_SAMPLE: begin
        st_nxt.init = pin_mux_pkg::ST_RUN;
        st_nxt.strap_low = ~st_r.strap_s2;
        if (!st_r.strap_s2) begin
          st_nxt.func_en = st_nxt.func_en &
            ~pin_mux_pkg::STRAP_MASK;
        end
      end
      pin_mux_pkg::ST_RUN: begin
        st_nxt.init = pin_mux_pkg::ST_RUN;
      end
      default: begin
        st_nxt.init = pin_mux_pkg::ST_FILL0;
      end
    endcase

    // pin drive and pull selection
    for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
      if (st_r.func_en[i]) begin
        // open-drain: a one releases the pin
        st_nxt.drv_out[i] = 1'b0;
        st_nxt.drv_oe_n[i] = ~(st_r.dir_out[i] &
          ~st_r.out_data[i]);
        st_nxt.pull_up[i] = ~st_r.pull_dn_cfg[i];
        st_nxt.pull_dn[i] = st_r.pull_dn_cfg[i];
      end else if (i == pin_mux_pkg::SHARED_PIN) begin
        st_nxt.drv_out[i] = shared_val;
        st_nxt.drv_oe_n[i] = 1'b0;
        st_nxt.pull_up[i] = 1'b0;
        st_nxt.pull_dn[i] = 1'b0;
      end else begin
        st_nxt.drv_out[i] = norm_out[i];
        st_nxt.drv_oe_n[i] = ~norm_drive[i];
        st_nxt.pull_up[i] = 1'b0;
        st_nxt.pull_dn[i] = 1'b0;
      end
    end

    // read data stands in the cycle after the strobe only
    if (reg_rd) begin
      st_nxt.rdata = rd_word;
    end else begin
      st_nxt.rdata = pin_mux_pkg::ZERO_WORD;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.pad_s1 <= pin_mux_pkg::ZERO_WORD;
      st_r.pad_s2 <= pin_mux_pkg::ZERO_WORD;
      st_r.strap_s1 <= 1'b1;
      st_r.strap_s2 <= 1'b1;
      st_r.init <= pin_mux_pkg::ST_FILL0;
      st_r.strap_low <= 1'b0;
      st_r.func_en <= pin_mux_pkg::RST_FUNC_EN;
      st_r.dir_out <= pin_mux_pkg::ZERO_WORD;
      st_r.pull_dn_cfg <= pin_mux_pkg::RST_PULL_DN;
      st_r.out_data <= pin_mux_pkg::ONES_WORD;
      st_r.aux_fn <= pin_mux_pkg::RST_AUX_FN;
      st_r.pbase <= pin_mux_pkg::RST_PBASE;
      st_r.rdata <= pin_mux_pkg::ZERO_WORD;
      st_r.drv_out <= pin_mux_pkg::ZERO_WORD;
      st_r.drv_oe_n <= pin_mux_pkg::ONES_WORD;
      st_r.pull_up <= pin_mux_pkg::RST_PULL_UP_PIN;
      st_r.pull_dn <= pin_mux_pkg::RST_PULL_DN_PIN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = st_r.rdata;
  assign pad_out = st_r.drv_out;
  assign pad_oe_n = st_r.drv_oe_n;
  assign pad_pull_up = st_r.pull_up;
  assign pad_pull_dn = st_r.pull_dn;
  assign norm_in = st_r.pad_s2;
  assign periph_select_n = psel_n;
  assign periph_select_seven = psel_n[pin_mux_pkg::SEL_SEVEN];
  assign latched_addr_bit_two = addr_two;
  assign strap_low_seen = st_r.strap_low;

endmodule
`default_nettype wire

// ===== design/pin_mux_pkg.sv
// constants and types shared by the programmable pin multiplexer
// Summary of operation
// - There are 32 programmable pins, each with function enable, direction and pull choice.
// - After reset pins 1, 10, 22 and 23 are pulled-down inputs; 0, 2, 3, 11-21 and 24-31 are pulled-up inputs.
// - Pins 7 to 9 leave reset in their upper address function so the first fetch reaches the boot address.
// - Pins 4, 5 and 6 leave reset in their normal bus function, not as programmable pins.
// - Pins that default to normal use offer a pullup when reprogrammed, and pin 6 offers a pulldown.
// - Pins 26 and 29 return to their normal function when the address enable strap is low at reset.
// - The seventh peripheral select goes low while an access hits the seventh peripheral region.
// - The seventh peripheral select stays high during bus hold and during reset.
// - Every peripheral select covers one contiguous 256-byte range of the peripheral block.
// - Peripheral selects follow the address phase of the multiplexed bus.
// - With the pin function bit at 0 the shared pin carries latched address bit 2 instead.
// - During bus hold the latched address bit 2 keeps its last value.
package pin_mux_pkg;

  localparam int NUM_PINS = 32;
  localparam int REG_AW = 3;
  localparam int REG_DW = 32;
  localparam int BUS_AW = 20;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [REG_AW-1:0] OFS_FUNC_EN = 3'h0;
  localparam logic [REG_AW-1:0] OFS_DIR = 3'h1;
  localparam logic [REG_AW-1:0] OFS_PULL_DN = 3'h2;
  localparam logic [REG_AW-1:0] OFS_DATA = 3'h3;
  localparam logic [REG_AW-1:0] OFS_AUX = 3'h4;
  localparam logic [REG_AW-1:0] OFS_PBASE = 3'h5;
  localparam logic [REG_AW-1:0] OFS_STATUS = 3'h6;
  localparam logic [REG_AW-1:0] OFS_DRIVEN = 3'h7;

  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [31:0] RST_FUNC_EN = 32'hfffffc0f;
  localparam logic [31:0] RST_PULL_DN = 32'h00c00442;
  localparam logic [31:0] RST_PULL_UP_PIN = RST_FUNC_EN & ~RST_PULL_DN;
  localparam logic [31:0] RST_PULL_DN_PIN = RST_FUNC_EN & RST_PULL_DN;
  localparam logic [31:0] STRAP_MASK = 32'h24000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [31:0] ONES_WORD = 32'hffffffff;
  localparam logic RST_AUX_FN = 1'b1;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SHARED_PIN = 2;
  localparam int AUX_FN_BIT = 0;
  localparam int PB_W = 10;
  localparam int PB_MEM_BIT = 9;
  localparam logic [PB_W-1:0] RST_PBASE = 10'h000;
  localparam int STAT_STRAP_BIT = 0;
  localparam int STAT_READY_BIT = 1;

  // ****************************************
  // peripheral block decode
  // ****************************************
  localparam int NUM_PSEL = 7;
  localparam int SEL_SEVEN = 6;
  localparam int REGION_LSB = 8;
  localparam int BLOCK_LSB = 11;
  localparam int ADDR_BIT_TWO = 2;

  typedef enum logic [1:0] {
    ST_FILL0 = 2'h0,
    ST_FILL1 = 2'h1,
    ST_SAMPLE = 2'h3,
    ST_RUN = 2'h2
  } init_state_t;

endpackage

// ===== design/periph_decode.sv
// peripheral block select decoder with latched address bit 2
`timescale 1ns/1ns
`default_nettype none
module periph_decode (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [pin_mux_pkg::BUS_AW-1:0] bus_addr,
  input wire logic addr_phase,
  input wire logic cycle_end,
  input wire logic bus_hold,
  input wire logic io_space,
  input wire logic [pin_mux_pkg::PB_W-1:0] pbase_cfg,
  output logic [pin_mux_pkg::NUM_PSEL-1:0] periph_select_n,
  output logic latched_addr_bit_two
);

  typedef struct packed {
    logic [pin_mux_pkg::NUM_PSEL-1:0] sel_n;
    logic addr_two;
  } dec_state_t;

  dec_state_t st_r;
  dec_state_t st_nxt;
  logic space_ok;

  function automatic logic region_hit(
    input logic [pin_mux_pkg::BUS_AW-1:0] a,
    input logic [pin_mux_pkg::PB_MEM_BIT-1:0] base,
    input logic [2:0] k
  );
    return (a[pin_mux_pkg::BUS_AW-1:pin_mux_pkg::BLOCK_LSB] == base) &&
      (a[pin_mux_pkg::BLOCK_LSB-1:pin_mux_pkg::REGION_LSB] == k);
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    space_ok = pbase_cfg[pin_mux_pkg::PB_MEM_BIT] ? ~io_space : io_space;
    if (bus_hold) begin
      st_nxt.sel_n = '1;
    end else if (addr_phase) begin
      for (int k = 0; k < pin_mux_pkg::NUM_PSEL; k++) begin
        st_nxt.sel_n[k] = ~(space_ok & region_hit(bus_addr,
          pbase_cfg[pin_mux_pkg::PB_MEM_BIT-1:0], 3'(k)));
      end
      st_nxt.addr_two = bus_addr[pin_mux_pkg::ADDR_BIT_TWO];
    end else if (cycle_end) begin
      st_nxt.sel_n = '1;
    end
  end

  // held value of addr_two is kept through hold
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.sel_n <= '1;
      st_r.addr_two <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign periph_select_n = st_r.sel_n;
  assign latched_addr_bit_two = st_r.addr_two;

endmodule
`default_nettype wire

// ===== bench/pin_mux_asserts.sv
// assertion checker for the programmable pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module pin_mux_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [19:0] bus_addr,
  input wire logic addr_phase,
  input wire logic cycle_end,
  input wire logic bus_hold,
  input wire logic [6:0] periph_select_n,
  input wire logic periph_select_seven,
  input wire logic latched_addr_bit_two,
  input wire logic [31:0] pad_pull_up,
  input wire logic [31:0] pad_pull_dn
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // address phase accepted by the decoder
  sequence take_s;
    addr_phase && !bus_hold;
  endsequence
  hold_sel_a: assert property (bus_hold |=> &periph_select_n)
    else $error("select low after bus hold");
  seven_sel_a: assert property (periph_select_seven == periph_select_n[6])
    else $error("seventh select differs from decode");
  hold_latch_a: assert property (bus_hold |=> $stable(latched_addr_bit_two))
    else $error("latched bit changed in hold");
  latch_bit_a: assert property (take_s |=> latched_addr_bit_two == $past(bus_addr[2]))
    else $error("latched bit not address bit two");
  no_region_a: assert property (take_s and bus_addr[10:8] == 3'h7 |=> &periph_select_n)
    else $error("select for unused region");
  one_sel_a: assert property ($onehot0(~periph_select_n))
    else $error("two selects low together");
  cycle_rel_a: assert property (cycle_end && !addr_phase |=> &periph_select_n)
    else $error("select held past cycle end");
  pull_excl_a: assert property ((pad_pull_up & pad_pull_dn) == 32'h00000000)
    else $error("pullup and pulldown together");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside read slot");
endmodule
bind pin_mux pin_mux_asserts chk (.clk, .sys_rst, .reg_rd, .reg_rdata,
  .bus_addr, .addr_phase, .cycle_end, .bus_hold, .periph_select_n,
  .periph_select_seven, .latched_addr_bit_two, .pad_pull_up, .pad_pull_dn);
`default_nettype wire

// ===== bench/bus_periph_model.sv
// far side pins: resolves each package pin from all of its drivers
`timescale 1ns/1ns
`default_nettype none
module bus_periph_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe_n,
  input wire logic [31:0] pad_pull_up,
  input wire logic [31:0] pad_pull_dn,
  input wire logic [31:0] drv_en,
  input wire logic [31:0] drv_val,
  output logic [31:0] pad_in
);
  logic [31:0] last_r;
  logic [31:0] ext_en;
  // never pull the status pin low while reset is held
  assign ext_en = drv_en & ~({32{sys_rst}} & 32'h20000000 & ~drv_val);
  always_ff @(posedge clk) begin
    if (sys_rst) last_r <= 32'h00000000;
    else last_r <= pad_in;
  end
  // floating pins toggle so a stale level never passes
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = drv_val[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_pull_dn[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~last_r[i];
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_pin_mux.sv
// self-checking testbench for the programmable pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module tb_pin_mux;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, addr_phase = 0;
  logic cycle_end = 0, bus_hold = 0, io_space = 0, address_enable_strap = 1;
  logic [2:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, norm_out = 0, norm_drive = 0;
  logic [31:0] drv_en = 0, drv_val = 0, r;
  logic [31:0] reg_rdata, pad_in, pad_out, pad_oe_n;
  logic [31:0] pad_pull_up, pad_pull_dn, norm_in;
  logic [19:0] bus_addr = 0;
  logic [8:0] b;
  logic [6:0] periph_select_n;
  logic periph_select_seven, latched_addr_bit_two, strap_low_seen;
  logic pend = 0, aux_v = 1;
  int num_errors = 0, n_tests = 0;
  logic [31:0] exp_q[$];
  always #25 clk = ~clk;
  pin_mux dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pad_in, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_dn,
    .address_enable_strap, .norm_out, .norm_drive, .norm_in, .bus_addr,
    .addr_phase, .cycle_end, .bus_hold, .io_space, .periph_select_n,
    .periph_select_seven, .latched_addr_bit_two, .strap_low_seen);
  bus_periph_model model (.clk, .sys_rst, .pad_out, .pad_oe_n, .pad_pull_up,
    .pad_pull_dn, .drv_en, .drv_val, .pad_in);
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e) begin
      num_errors++;
      $display("[ERR] %0t: got %h want %h", $time, seen, e);
    end
  endtask
  task automatic drv(input logic w, input logic rd, input logic [2:0] a,
      input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    drv(1, 0, a, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    drv(0, 1, a, 0);
  endtask
  task automatic idle(input int n);
    repeat (n) drv(0, 0, 0, 0);
  endtask
  task automatic bcyc(input logic [19:0] a, input logic io,
      input logic [6:0] es, input logic el);
    bus_addr <= a;
    io_space <= io;
    addr_phase <= 1;
    @(posedge clk);
    addr_phase <= 0;
    @(negedge clk);
    chk(periph_select_n, es);
    chk(latched_addr_bit_two, el);
    @(posedge clk);
    cycle_end <= 1;
    @(negedge clk);
    chk(pad_out[2], aux_v ? es[6] : el);
    chk(pad_oe_n[2], 1'b0);
    @(posedge clk);
    cycle_end <= 0;
    @(negedge clk);
    chk(periph_select_n, 7'h7f);
    @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // read data stand in the cycle after the strobe
  always @(negedge clk) begin
    if (pend) chk(reg_rdata, exp_q.pop_front());
    pend = reg_rd;
  end
  initial begin
    #250000;
    num_errors++;
    summarize;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h826d36b7));
    repeat (10) @(posedge clk);
    chk(pad_oe_n, 32'hffffffff);
    chk(pad_pull_up, 32'hff3ff80d);
    chk(pad_pull_dn, 32'h00c00402);
    chk(periph_select_n, 7'h7f);
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    norm_out <= $urandom;
    norm_drive <= $urandom;
    idle(4);
    rd(6, 32'h2);
    rd(0, 32'hfffffc0f);
    rd(2, 32'h00c00442);
    rd(4, 32'h1);
    rd(7, norm_drive & 32'h3f0);
    wr(6, 32'hffffffff);
    rd(6, 32'h2);
    idle(1);
    @(negedge clk);
    chk(pad_out[9:4], norm_out[9:4]);
    chk(pad_oe_n[9:4] ^ norm_drive[9:4], 6'h3f);
    chk(pad_pull_up[9:4] | pad_pull_dn[9:4], 6'h00);
    @(posedge clk);
    r = $urandom;
    wr(0, 32'hffffffff);
    wr(1, r);
    wr(3, 32'h0);
    idle(2);
    @(negedge clk);
    chk(pad_oe_n, ~r);
    @(posedge clk);
    wr(3, 32'hffffffff);
    wr(1, 32'h0);
    idle(2);
    @(negedge clk);
    chk(pad_oe_n, 32'hffffffff);
    chk(pad_pull_dn, 32'h00c00442);
    chk(pad_pull_up, 32'hff3ffbbd);
    @(posedge clk);
    idle(3);
    rd(3, 32'hff3ffbbd);
    drv_en <= 32'hffffffff;
    drv_val <= r;
    idle(4);
    @(negedge clk);
    chk(norm_in, r);
    @(posedge clk);
    rd(3, r);
    drv_en <= 32'h0;
    idle(1);
    // pin two back to its shared function, block in I/O space
    b = 9'($urandom);
    wr(0, 32'hfffffc0b);
    wr(5, {23'h0, b});
    idle(2);
    for (int k = 0; k < 8; k++) begin
      r = {b, k[2:0], 8'h00} | ($urandom & 32'hff);
      bcyc(r[19:0], 1'b1, k < 7 ? ~(7'h1 << k) : 7'h7f, r[2]);
    end
    bcyc({b, 3'h6, 8'h44}, 1'b0, 7'h7f, 1'b1);
    wr(4, 32'h0);
    aux_v = 0;
    idle(2);
    bcyc({b, 3'h0, 8'h40}, 1'b1, 7'h7e, 1'b0);
    bus_hold <= 1;
    bcyc({b, 3'h6, 8'h44}, 1'b1, 7'h7f, 1'b0);
    bus_hold <= 0;
    sys_rst <= 1;
    address_enable_strap <= 0;
    idle(20);
    sys_rst <= 0;
    idle(5);
    rd(6, 32'h3);
    rd(0, 32'hdbfffc0f);
    idle(2);
    @(negedge clk);
    chk(strap_low_seen, 1'b1);
    chk(pad_oe_n[29] ^ norm_drive[29], 1'b1);
    @(posedge clk);
    summarize;
  end
endmodule
`default_nettype wire
